// *** pkg/ssb_pkg.sv ***
// Constants and carrier types for the shift, clamp and bitfield unit.
// Assumes a single core clock and a register file that consumes results.
// Contract
// [RULE1] Narrow 40-bit signed to 32 with clamping
// [RULE2] Clamp flag set cycle after write
// [RULE3] Bitfield set forces low..high bits to one
// [RULE4] Register form: high 4..0, low 9..5
// [RULE5] Software keeps upper 22 position bits zero
// [RULE6] Register amount six bits, immediate five
// [RULE7] Amount 40 to 63 shifts by forty
// [RULE8] Software keeps upper 26 amount bits zero
// [RULE9] Right shift fills with sign bit
// [RULE10] One stage result; false predicate no write
// [RULE11] Left shift zero fills, sized destination
package ssb_pkg;
  localparam int unsigned WORD_W    = 32;
  localparam int unsigned LONG_W    = 40;
  localparam int unsigned AMT_W     = 6;
  localparam int unsigned IMM_W     = 5;
  localparam int unsigned POS_W     = 5;
  localparam int unsigned HI_LSB    = 0;
  localparam int unsigned LO_LSB    = 5;
  localparam logic [5:0]  SHIFT_MAX = 6'h28;
  localparam logic [39:0] POS_LIM   = 40'h007FFFFFFF;
  localparam logic [39:0] NEG_LIM   = 40'hFF80000000;
  localparam logic [39:0] RST_RES   = 40'h0000000000;

  typedef enum logic [1:0] {
    SSB_OP_CLAMP,
    SSB_OP_SET,
    SSB_OP_SHL,
    SSB_OP_SHR
  } ssb_op_e;

  typedef struct packed {
    logic        valid;
    logic        pred;
    ssb_op_e     op;
    logic        is_long;
    logic        use_imm;
    logic [39:0] src;
    logic [31:0] shift_operand;
    logic [4:0]  imm_a;
    logic [4:0]  imm_b;
  } ssb_req_s;

  typedef struct packed {
    logic        wr_en;
    logic        wr_long;
    logic [39:0] wr_data;
    logic        clamp_flag;
  } ssb_rsp_s;
endpackage

// *** hw/ssb_field_mask.sv ***
// Field mask builder for the bitfield set operation.
// Assumes positions in range 0..31; low above high gives an empty mask.
`timescale 1ns/1ns
module ssb_field_mask #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic [4:0]       lo_in,
  input  wire logic [4:0]       hi_in,
  output logic      [WIDTH-1:0] mask_out
);
  // Positions are five bits wide, so only a 32-bit word can be served
  if (WIDTH != 32)
  begin : g_bad_width
    $error("ssb_field_mask supports only WIDTH 32");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // [RULE3] Bit inside field
      assign mask_out[i] = (5'(i) >= lo_in) && (5'(i) <= hi_in);
    end
  endgenerate
endmodule // ssb_field_mask

// *** hw/ssb_unit.sv ***
// Execute stage for clamp-narrow, bitfield set and arithmetic shifts.
// Assumes issue logic presents one request a cycle, on clk_in.
`timescale 1ns/1ns
module ssb_unit (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire ssb_pkg::ssb_req_s req_in,
  output ssb_pkg::ssb_rsp_s      rsp_out
);
  typedef struct packed {
    ssb_pkg::ssb_rsp_s rsp;
    logic              clamp_pend;
  } ssb_state_s;

  ssb_state_s  state_q;
  ssb_state_s  state_d;
  logic [31:0] mask;
  logic [4:0]  fld_lo;
  logic [4:0]  fld_hi;

  // [RULE4] Position source select
  assign fld_hi = req_in.use_imm ? req_in.imm_b :
    req_in.shift_operand[ssb_pkg::HI_LSB +: ssb_pkg::POS_W];
  assign fld_lo = req_in.use_imm ? req_in.imm_a :
    req_in.shift_operand[ssb_pkg::LO_LSB +: ssb_pkg::POS_W];

  ssb_field_mask #(.WIDTH(32)) u_mask (
    .lo_in    (fld_lo),
    .hi_in    (fld_hi),
    .mask_out (mask)
  );

  always_comb
  begin
    logic [5:0]  amt;
    logic [39:0] src_ext;
    logic [39:0] res;
    logic        clamped;
    amt     = 6'h00;
    src_ext = 40'h0000000000;
    res     = 40'h0000000000;
    clamped = 1'b0;
    state_d = state_q;
    // [RULE6] Amount width by form
    if (req_in.use_imm)
      amt = {1'b0, req_in.imm_a};
    else
      amt = req_in.shift_operand[ssb_pkg::AMT_W-1:0];
    // [RULE7] Large amounts act as forty
    if (amt > ssb_pkg::SHIFT_MAX)
      amt = ssb_pkg::SHIFT_MAX;
    if (req_in.is_long)
      src_ext = req_in.src;
    else
      src_ext = {{8{req_in.src[31]}}, req_in.src[31:0]};
    case (req_in.op)
      ssb_pkg::SSB_OP_CLAMP:
      begin
        // [RULE1] Clamp to signed 32-bit range
        if ($signed(req_in.src) > $signed(ssb_pkg::POS_LIM))
        begin
          res     = ssb_pkg::POS_LIM;
          clamped = 1'b1;
        end
        else if ($signed(req_in.src) < $signed(ssb_pkg::NEG_LIM))
        begin
          res     = {8'h00, ssb_pkg::NEG_LIM[31:0]};
          clamped = 1'b1;
        end
        else
          res = {8'h00, req_in.src[31:0]};
      end
      ssb_pkg::SSB_OP_SET:
        res = {8'h00, req_in.src[31:0] | mask};
      ssb_pkg::SSB_OP_SHL:
      begin
        // [RULE11] Zero fill, sized result
        res = src_ext << amt;
        if (!req_in.is_long)
          res = {8'h00, res[31:0]};
      end
      default:
      begin
        // [RULE9] Sign fill right shift
        res = 40'($signed(src_ext) >>> amt);
        if (!req_in.is_long)
          res = {8'h00, res[31:0]};
      end
    endcase
    // [RULE10] Predicated single-stage write
    state_d.rsp.wr_en   = req_in.valid && req_in.pred;
    state_d.rsp.wr_long = req_in.is_long &&
      (req_in.op == ssb_pkg::SSB_OP_SHL ||
       req_in.op == ssb_pkg::SSB_OP_SHR);
    state_d.rsp.wr_data = state_d.rsp.wr_en ? res : state_q.rsp.wr_data;
    state_d.clamp_pend  = state_d.rsp.wr_en && clamped &&
      (req_in.op == ssb_pkg::SSB_OP_CLAMP);
    // [RULE2] Sticky flag one cycle after write
    state_d.rsp.clamp_flag = state_q.rsp.clamp_flag | state_q.clamp_pend;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q.rsp.wr_en      <= 1'b0;
      state_q.rsp.wr_long    <= 1'b0;
      state_q.rsp.wr_data    <= ssb_pkg::RST_RES;
      state_q.rsp.clamp_flag <= 1'b0;
      state_q.clamp_pend     <= 1'b0;
    end
    else
      state_q <= state_d;
  end

  assign rsp_out = state_q.rsp;
endmodule // ssb_unit

// *** tb/ssb_regfile.sv ***
// Register file stand-in: keeps the last written result.
// Assumes the unit's clock and write port.
`timescale 1ns/1ns
module ssb_regfile (
  input  wire logic              clk_in,
  input  wire ssb_pkg::ssb_rsp_s rsp_in,
  output logic [39:0]            dst_out
);
  always_ff @(posedge clk_in)
    if (rsp_in.wr_en) dst_out <= rsp_in.wr_data;
endmodule // ssb_regfile

// *** tb/ssb_unit_assertions.sv ***
// Port checker for the execute unit.
// Assumes a bind to ssb_unit.
`timescale 1ns/1ns
module ssb_assertions (
  input wire logic              clk_in,
  input wire logic              rst_n_in,
  input wire ssb_pkg::ssb_req_s req_in,
  input wire ssb_pkg::ssb_rsp_s rsp_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ssb_pkg::ssb_req_s r;
  logic [1:0]        op;
  logic              go, ov, un, sr, big;
  always_ff @(posedge clk_in) r <= req_in;
  assign op = req_in.op;
  assign go = req_in.valid && req_in.pred;
  assign ov = go && op == 2'h0 && $signed(req_in.src) > 40'sh007FFFFFFF;
  assign un = go && op == 2'h0 && $signed(req_in.src) < 40'shFF80000000;
  assign sr = go && op == 2'h1 && !req_in.use_imm
              && req_in.shift_operand[9:5] <= req_in.shift_operand[4:0];
  assign big = go && !req_in.use_imm && req_in.shift_operand[5:0] > 6'h27;
  property p_wr; go |=> rsp_out.wr_en; endproperty
  a_wr: assert property (p_wr) else $error("no write");
  property p_nowr; !go |=> !rsp_out.wr_en; endproperty
  a_nowr: assert property (p_nowr) else $error("stray write");
  property p_ov; ov |=> rsp_out.wr_data == 40'h007FFFFFFF; endproperty
  a_ov: assert property (p_ov) else $error("bad high clamp");
  property p_un; un |=> rsp_out.wr_data == 40'h0080000000; endproperty
  a_un: assert property (p_un) else $error("bad low clamp");
  property p_flag; ov || un |=> ##1 rsp_out.clamp_flag; endproperty
  a_flag: assert property (p_flag) else $error("flag late");
  property p_set; sr |=> rsp_out.wr_data[r.shift_operand[4:0]]; endproperty
  a_set: assert property (p_set) else $error("field top clear");
  property p_shl; big && op == 2'h2 |=> rsp_out.wr_data == 40'h0; endproperty
  a_shl: assert property (p_shl) else $error("left by forty");
  property p_shr; big && op == 2'h3 && req_in.is_long |=>
    rsp_out.wr_data == {40{r.src[39]}}; endproperty
  a_shr: assert property (p_shr) else $error("right by forty");
  property p_long; go |=> rsp_out.wr_long == (r.is_long && r.op[1]);
  endproperty
  a_long: assert property (p_long) else $error("bad width");
  c_flag: cover property (rsp_out.clamp_flag);
  c_set: cover property (sr);
  c_big: cover property (big);
endmodule // ssb_assertions

// *** tb/tb_shift_saturate_bitfield_unit.sv ***
// Self-checking bench for the shift, clamp and bitfield unit.
// Assumes the unit answers one cycle after a taken request.
`timescale 1ns/1ns
module tb_shift_saturate_bitfield_unit;
  logic              clk_in   = 1'h0;
  logic              rst_n_in = 1'h0;
  ssb_pkg::ssb_req_s req_in   = '0;
  ssb_pkg::ssb_rsp_s rsp_out;
  logic [39:0]       d;
  int                error_cnt = 0, n_checks = 0;
  always #10 clk_in = ~clk_in;
  ssb_unit u_ssb_unit (.clk_in(clk_in), .rst_n_in(rst_n_in),
                       .req_in(req_in), .rsp_out(rsp_out));
  ssb_regfile u_ssb_regfile (.clk_in(clk_in), .rsp_in(rsp_out), .dst_out(d));
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [40:0] g, e);
    n_checks++;
    error_cnt += int'(g !== e);
    if (g !== e)
      $display("mismatch %0t %h %h", $time, g, e);
  endtask
  // Mode nibble: is_long, use_imm, op; positions packed as in registers
  task automatic chk(input logic [3:0] m, input logic [31:0] o,
                     input logic [39:0] s, e);
    @(negedge clk_in);
    req_in = '{1'h1, 1'h1, ssb_pkg::ssb_op_e'(m[1:0]), m[3], m[2], s, o,
               o[9:5], o[4:0]};
    @(negedge clk_in);
    req_in.valid = 1'h0;
    cmp({rsp_out.wr_en, rsp_out.wr_data}, {1'h1, e});
  endtask
  task automatic t_clamp();
    chk(4'h0, 32'h0, 40'hFF80000000, 40'h0080000000);
    chk(4'h0, 32'h0, 40'h0080000000, 40'h007FFFFFFF);
    cmp(41'(rsp_out.clamp_flag), 41'h0);
    @(negedge clk_in);
    cmp(41'(rsp_out.clamp_flag), 41'h1);
    chk(4'h0, 32'h0, 40'hFF7FFFFFFF, 40'h0080000000);
  endtask
  task automatic t_set();
    chk(4'h5, 32'hF5, 40'h4B134A1E, 40'h4B3FFF9E);
    chk(4'h1, 32'hC197, 40'h9ED31A31, 40'h9EFFFA31);
  endtask
  task automatic t_shift();
    chk(4'h6, 32'h80, 40'h29E3D31C, 40'h9E3D31C0);
    chk(4'hA, 32'h22, 40'h09419751A5, 40'h9400000000);
    chk(4'h7, 32'h100, 40'hF12363D1, 40'h00FFF12363);
    chk(4'hB, 32'h19, 40'h1214925A41, 40'h000000090A);
    chk(4'h2, 32'h3F, 40'h12345678, 40'h0);
    chk(4'hB, 32'h2D, 40'h8000000001, 40'hFFFFFFFFFF);
    @(negedge clk_in);
    req_in.pred = 1'h0;
    req_in.valid = 1'h1;
    @(negedge clk_in);
    cmp({rsp_out.wr_en, d}, {1'h0, 40'hFFFFFFFFFF});
    cmp(41'(rsp_out.wr_data), 41'hFFFFFFFFFF);
  endtask
  initial
  begin
    repeat (999) @(posedge clk_in);
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'h1;
    t_clamp();
    t_set();
    t_shift();
    report_and_stop();
  end
endmodule // tb_shift_saturate_bitfield_unit
bind ssb_unit ssb_assertions u_ssb_assertions (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .req_in(req_in), .rsp_out(rsp_out));
